// >>> inc/rtfmt_regs.vh
// Register map, field positions, reset values and forced codes of the result formatter
`ifndef RTFMT_REGS_VH
`define RTFMT_REGS_VH

`define RTFMT_OFS_LOCAL      8'h00
`define RTFMT_OFS_RS_MSB     8'h04
`define RTFMT_OFS_RS_LSB     8'h08
`define RTFMT_OFS_RU_MSB     8'h0C
`define RTFMT_OFS_RU_LSB     8'h10
`define RTFMT_OFS_STATUS     8'h14
`define RTFMT_OFS_CONFIG     8'h18
`define RTFMT_OFS_CRIT_WR    8'h1C
`define RTFMT_OFS_CRIT_RD    8'h20
`define RTFMT_OFS_HIGH       8'h24

`define RTFMT_CFG_ALERT_MASK 0
`define RTFMT_CFG_CRIT_MASK  1
`define RTFMT_CFG_USF        2
`define RTFMT_CFG_FILT_LO    3
`define RTFMT_CFG_FILT_HI    4

`define RTFMT_ST_CRIT        1
`define RTFMT_ST_FAULT       2
`define RTFMT_ST_HIGH        4

`define RTFMT_RST_CONFIG     8'h00
`define RTFMT_RST_CRIT       8'h55
`define RTFMT_RST_HIGH       8'h46

`define RTFMT_FILT_NONE      2'b00
`define RTFMT_FILT_STD       2'b01
`define RTFMT_FILT_RSVD      2'b10
`define RTFMT_FILT_ENH       2'b11

`define RTFMT_S_FORCE_GND    16'h8000
`define RTFMT_S_FORCE_OPEN   16'h7F00
`define RTFMT_U_FORCE_GND    16'h0000
`define RTFMT_U_FORCE_OPEN   16'hFF00

`define RTFMT_S_MAX          16'sd4095
`define RTFMT_S_MIN          -16'sd4096
`define RTFMT_U_MAX          16'sd8191
`define RTFMT_CLIP_STEP      17'sd128

`define RTFMT_RESP_OKAY      2'b00
`define RTFMT_RESP_SLVERR    2'b10

`endif

// >>> rtl/rtfmt_top.v
// Temperature result formatter, diode fault forcing, remote filter and AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rtfmt_regs.vh"

module rtfmt_top #(
  parameter ADDR_W = 8,
  parameter RAW_W  = 16
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // Conversion front end, 1/32 degree signed samples
  input  wire              conv_done,
  input  wire [RAW_W-1:0]  remote_raw,
  input  wire [RAW_W-1:0]  local_raw,
  // Diode fault comparators, asynchronous
  input  wire              diode_short_gnd,
  input  wire              diode_open,
  input  wire              diode_short_vdd,
  // Open-drain pins
  output reg               alert_pin,
  output reg               alert_pin_oe_n,
  output reg               critical_temp_output,
  output reg               critical_temp_output_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Fault input synchronisers
  reg [2:0] flt_meta;
  reg [2:0] flt_sync;

  always @(posedge aclk) begin
    if (!aresetn) begin
      flt_meta <= 3'h0;
      flt_sync <= 3'h0;
    end else begin
      flt_meta <= {diode_short_vdd, diode_open, diode_short_gnd};
      flt_sync <= flt_meta;
    end
  end

  wire fault_gnd  = flt_sync[0];
  wire fault_high = flt_sync[1] | flt_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Software state
  reg [7:0] config_reg;
  reg [7:0] critical_setpoint;
  reg [7:0] high_setpoint;

  wire [1:0] remote_filter_select = config_reg[`RTFMT_CFG_FILT_HI:`RTFMT_CFG_FILT_LO];
  wire       unsigned_format_select = config_reg[`RTFMT_CFG_USF];
  wire       filtering = (remote_filter_select == `RTFMT_FILT_STD) ||
                         (remote_filter_select == `RTFMT_FILT_ENH);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion results
  reg signed [RAW_W-1:0] filt;
  reg        [15:0]      sword;
  reg        [15:0]      uword;
  reg        [7:0]       local_res;
  reg                    diode_fault_flag;
  reg                    crit_status;
  reg                    high_status;

  reg signed [RAW_W:0]   diff;
  reg signed [RAW_W:0]   step;
  reg signed [RAW_W:0]   sum;
  reg signed [RAW_W-1:0] next_filt;
  reg signed [RAW_W-1:0] sv;
  reg signed [RAW_W-1:0] uv;
  reg signed [RAW_W-1:0] lv;
  reg        [15:0]      next_sword;
  reg        [15:0]      next_uword;
  reg        [7:0]       next_local;
  reg signed [8:0]       rem_int;
  reg signed [8:0]       crit_int;
  reg signed [8:0]       high_int;

  always @* begin
    diff = $signed({remote_raw[RAW_W-1], remote_raw}) - $signed({filt[RAW_W-1], filt});
    step = diff;
    // Clipping keeps a single spike from dragging the average far
    if (remote_filter_select == `RTFMT_FILT_ENH) begin
      if (diff > `RTFMT_CLIP_STEP)
        step = `RTFMT_CLIP_STEP;
      else if (diff < -`RTFMT_CLIP_STEP)
        step = -`RTFMT_CLIP_STEP;
    end
    sum = $signed({filt[RAW_W-1], filt}) + (step >>> 2);
    if (filtering)
      next_filt = sum[RAW_W-1:0];
    else
      next_filt = remote_raw;

    sv = next_filt;
    if (next_filt > `RTFMT_S_MAX)
      sv = `RTFMT_S_MAX;
    else if (next_filt < `RTFMT_S_MIN)
      sv = `RTFMT_S_MIN;
    uv = next_filt;
    if (next_filt < 0)
      uv = {RAW_W{1'b0}};
    else if (next_filt > `RTFMT_U_MAX)
      uv = `RTFMT_U_MAX;
    if (!filtering) begin
      sv[1:0] = 2'b00;
      uv[1:0] = 2'b00;
    end
    next_sword = {sv[12:0], 3'b000};
    next_uword = {uv[12:0], 3'b000};
    if (fault_gnd) begin
      next_sword = `RTFMT_S_FORCE_GND;
      next_uword = `RTFMT_U_FORCE_GND;
    end else if (fault_high) begin
      next_sword = `RTFMT_S_FORCE_OPEN;
      next_uword = `RTFMT_U_FORCE_OPEN;
    end

    lv = $signed(local_raw) >>> 5;
    if (lv > 127)
      next_local = 8'h7F;
    else if (lv < -128)
      next_local = 8'h80;
    else
      next_local = lv[7:0];

    // Comparisons run on the word that was just formatted, forced or not
    if (unsigned_format_select) begin
      rem_int  = {1'b0, next_uword[15:8]};
      crit_int = {1'b0, critical_setpoint};
      high_int = {1'b0, high_setpoint};
    end else begin
      rem_int  = {next_sword[15], next_sword[15:8]};
      crit_int = {critical_setpoint[7], critical_setpoint};
      high_int = {high_setpoint[7], high_setpoint};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      filt             <= {RAW_W{1'b0}};
      sword            <= 16'h0000;
      uword            <= 16'h0000;
      local_res        <= 8'h00;
      diode_fault_flag <= 1'b0;
      crit_status      <= 1'b0;
      high_status      <= 1'b0;
    end else if (conv_done) begin
      // All results commit on the same edge so a read never mixes samples
      filt             <= next_filt;
      sword            <= next_sword;
      uword            <= next_uword;
      local_res        <= next_local;
      diode_fault_flag <= fault_high & ~fault_gnd;
      crit_status      <= rem_int > crit_int;
      high_status      <= rem_int > high_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins; the fault flag deliberately feeds neither
  always @(posedge aclk) begin
    if (!aresetn) begin
      alert_pin                 <= 1'b0;
      alert_pin_oe_n            <= 1'b1;
      critical_temp_output      <= 1'b0;
      critical_temp_output_oe_n <= 1'b1;
    end else begin
      alert_pin                 <= 1'b0;
      critical_temp_output      <= 1'b0;
      alert_pin_oe_n            <= ~(high_status & ~config_reg[`RTFMT_CFG_ALERT_MASK]);
      critical_temp_output_oe_n <= ~(crit_status & ~config_reg[`RTFMT_CFG_CRIT_MASK]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  reg [ADDR_W-1:0] aw_addr;
  reg              aw_full;
  reg [7:0]        w_byte;
  reg              w_lane0;
  reg              w_full;
  reg [1:0]        wr_resp;

  always @* begin
    case (aw_addr)
      `RTFMT_OFS_CONFIG, `RTFMT_OFS_CRIT_WR, `RTFMT_OFS_HIGH,
      `RTFMT_OFS_LOCAL, `RTFMT_OFS_RS_MSB, `RTFMT_OFS_RS_LSB,
      `RTFMT_OFS_RU_MSB, `RTFMT_OFS_RU_LSB, `RTFMT_OFS_STATUS,
      `RTFMT_OFS_CRIT_RD: wr_resp = `RTFMT_RESP_OKAY;
      default:            wr_resp = `RTFMT_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready           <= 1'b0;
      wready            <= 1'b0;
      bvalid            <= 1'b0;
      bresp             <= `RTFMT_RESP_OKAY;
      aw_addr           <= {ADDR_W{1'b0}};
      aw_full           <= 1'b0;
      w_byte            <= 8'h00;
      w_lane0           <= 1'b0;
      w_full            <= 1'b0;
      config_reg        <= `RTFMT_RST_CONFIG;
      critical_setpoint <= `RTFMT_RST_CRIT;
      high_setpoint     <= `RTFMT_RST_HIGH;
    end else begin
      if (!awready && !aw_full && !bvalid)
        awready <= 1'b1;
      if (!wready && !w_full && !bvalid)
        wready <= 1'b1;
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
        w_full  <= 1'b1;
        wready  <= 1'b0;
      end
      if (aw_full && w_full && !bvalid) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_resp;
        // One data byte per register write; read-only offsets ignore it
        if (w_lane0) begin
          case (aw_addr)
            `RTFMT_OFS_CONFIG:  config_reg        <= w_byte & 8'h1F;
            `RTFMT_OFS_CRIT_WR: critical_setpoint <= w_byte;
            `RTFMT_OFS_HIGH:    high_setpoint     <= w_byte;
            default:            config_reg        <= config_reg;
          endcase
        end
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  reg [31:0] rd_word;
  reg [1:0]  rd_resp;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_resp = `RTFMT_RESP_OKAY;
    case (araddr)
      `RTFMT_OFS_LOCAL:   rd_word[7:0] = local_res;
      `RTFMT_OFS_RS_MSB:  rd_word[7:0] = sword[15:8];
      `RTFMT_OFS_RS_LSB:  rd_word[7:0] = sword[7:0];
      `RTFMT_OFS_RU_MSB:  rd_word[7:0] = uword[15:8];
      `RTFMT_OFS_RU_LSB:  rd_word[7:0] = uword[7:0];
      `RTFMT_OFS_STATUS: begin
        rd_word[`RTFMT_ST_CRIT]  = crit_status;
        rd_word[`RTFMT_ST_FAULT] = diode_fault_flag;
        rd_word[`RTFMT_ST_HIGH]  = high_status;
      end
      `RTFMT_OFS_CONFIG:  rd_word[7:0] = config_reg;
      `RTFMT_OFS_CRIT_WR: rd_word[7:0] = 8'h00;
      `RTFMT_OFS_CRIT_RD: rd_word[7:0] = critical_setpoint;
      `RTFMT_OFS_HIGH:    rd_word[7:0] = high_setpoint;
      default:            rd_resp = `RTFMT_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RTFMT_RESP_OKAY;
    end else begin
      if (!arready && !rvalid)
        arready <= 1'b1;
      if (arvalid && arready) begin
        rdata   <= rd_word;
        rresp   <= rd_resp;
        rvalid  <= 1'b1;
        arready <= 1'b0;
      end
      // Reads have no side effect, so any way the host ends one is safe
      if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule

// >>> verif/rtfmt_monitor.sv
// Assertions on bus answers, pin drive and pin causes of the formatter
`timescale 1ns/1ps
module rtfmt_monitor (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus responses
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  // Conversion and pins
  input wire        conv_done,
  input wire        alert_pin,
  input wire        alert_pin_oe_n,
  input wire        critical_temp_output,
  input wire        critical_temp_output_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_alert_low_only: assert property (alert_pin == 1'b0)
    else $error("alert pin high");
  a_crit_low_only: assert property (critical_temp_output == 1'b0)
    else $error("crit pin high");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_byte_wide: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("read data above byte");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_bresp_code: assert property (bvalid |-> bresp == 2'b00 || bresp == 2'b10)
    else $error("bad write response");
  // Pins may move only after a conversion or a register write
  a_crit_cause: assert property ($changed(critical_temp_output_oe_n) |->
    $past(conv_done, 2) || $past(bvalid)) else $error("crit pin moved alone");
  a_alert_cause: assert property ($changed(alert_pin_oe_n) |->
    $past(conv_done, 2) || $past(bvalid)) else $error("alert pin moved alone");
endmodule

bind rtfmt_top rtfmt_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .conv_done(conv_done), .alert_pin(alert_pin), .alert_pin_oe_n(alert_pin_oe_n),
  .critical_temp_output(critical_temp_output),
  .critical_temp_output_oe_n(critical_temp_output_oe_n)
);

// >>> verif/rtfmt_front.sv
// Model of the remote diode front end: samples, fault levels, conversion strobe
`timescale 1ns/1ps
module rtfmt_front (
  // Clock
  input  wire        aclk,
  // Conversion results
  output reg         conv_done = 1'b0,
  output reg  [15:0] remote_raw = 16'h0000,
  output reg  [15:0] local_raw = 16'h0000,
  // Diode fault levels
  output reg         diode_short_gnd = 1'b0,
  output reg         diode_open = 1'b0,
  output reg         diode_short_vdd = 1'b0
);
  task conv(input [15:0] r, input [15:0] l, input [2:0] f);
    begin
      @(posedge aclk);
      remote_raw <= r;
      local_raw <= l;
      {diode_short_vdd, diode_open, diode_short_gnd} <= f;
      // Faults pass a two-flop synchroniser, so settle first
      repeat (3) @(posedge aclk);
      conv_done <= 1'b1;
      @(posedge aclk);
      conv_done <= 1'b0;
      remote_raw <= ~r;
      local_raw <= ~l;
      @(posedge aclk);
    end
  endtask
endmodule

// >>> verif/rtfmt_top_tb.sv
// Self-checking bench: registers, formats, filter, faults and pins
`timescale 1ns/1ps
module rtfmt_top_tb;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg  [3:0]  wstrb = 4'h1;
  wire        awready, wready, bvalid, arready, rvalid, conv_done;
  wire        alert_pin, alert_pin_oe_n, critical_temp_output, critical_temp_output_oe_n;
  wire        diode_short_gnd, diode_open, diode_short_vdd;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] remote_raw, local_raw;
  integer     err_total = 0;
  integer     tests_run = 0;

  always #12.5 aclk = ~aclk;

  rtfmt_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_done(conv_done),
    .remote_raw(remote_raw), .local_raw(local_raw), .diode_short_gnd(diode_short_gnd),
    .diode_open(diode_open), .diode_short_vdd(diode_short_vdd), .alert_pin(alert_pin),
    .alert_pin_oe_n(alert_pin_oe_n), .critical_temp_output(critical_temp_output),
    .critical_temp_output_oe_n(critical_temp_output_oe_n)
  );
  rtfmt_front front_u (
    .aclk(aclk), .conv_done(conv_done), .remote_raw(remote_raw), .local_raw(local_raw),
    .diode_short_gnd(diode_short_gnd), .diode_open(diode_open),
    .diode_short_vdd(diode_short_vdd)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 64);
      if (!bvalid) begin
        err_total = err_total + 1;
        end_sim;
      end
      // Late ready makes the answer stand one cycle
      bready <= 1'b1;
      @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 64);
      if (!rvalid) begin
        err_total = err_total + 1;
        end_sim;
      end
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
      chk(rdata, {24'h00_0000, e});
      chk({30'h0, rresp}, {30'h0, er});
    end
  endtask
  task res(input [7:0] sm, input [7:0] sl, input [7:0] um, input [7:0] ul, input [7:0] lc);
    begin
      rd(8'h04, sm, 2'b00);
      rd(8'h08, sl, 2'b00);
      rd(8'h0C, um, 2'b00);
      rd(8'h10, ul, 2'b00);
      rd(8'h00, lc, 2'b00);
    end
  endtask
  task pins(input [1:0] e);
    begin
      repeat (2) @(posedge aclk);
      chk({30'h0, alert_pin_oe_n, critical_temp_output_oe_n}, {30'h0, e});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rd(8'h18, 8'h00, 2'b00);
      rd(8'h20, 8'h55, 2'b00);
      rd(8'h24, 8'h46, 2'b00);
      rd(8'h1C, 8'h00, 2'b00);
      rd(8'h28, 8'h00, 2'b10);
      wr(8'h28, 8'h5A, 2'b10);
      wr(8'h00, 8'h5A, 2'b00);
      rd(8'h00, 8'h00, 2'b00);
      wr(8'h18, 8'hFF, 2'b00);
      rd(8'h18, 8'h1F, 2'b00);
      wr(8'h18, 8'h00, 2'b00);
      // No byte lane, no store
      wstrb <= 4'h0;
      wr(8'h18, 8'h1F, 2'b00);
      rd(8'h18, 8'h00, 2'b00);
      wstrb <= 4'h1;
    end
  endtask
  task t_format;
    begin
      front_u.conv(16'h0331, 16'h0331, 3'b000);
      res(8'h19, 8'h80, 8'h19, 8'h80, 8'h19);
      front_u.conv(16'hFFFF, 16'hFFFF, 3'b000);
      res(8'hFF, 8'hE0, 8'h00, 8'h00, 8'hFF);
      front_u.conv(16'h2328, 16'h1388, 3'b000);
      res(8'h7F, 8'hE0, 8'hFF, 8'hE0, 8'h7F);
    end
  endtask
  task t_filter;
    begin
      wr(8'h18, 8'h10, 2'b00);
      front_u.conv(16'h0331, 16'h0331, 3'b000);
      res(8'h19, 8'h80, 8'h19, 8'h80, 8'h19);
      wr(8'h18, 8'h08, 2'b00);
      front_u.conv(16'h0351, 16'h0351, 3'b000);
      res(8'h19, 8'hC8, 8'h19, 8'hC8, 8'h1A);
      wr(8'h18, 8'h18, 2'b00);
      front_u.conv(16'h0B09, 16'h0B09, 3'b000);
      res(8'h1A, 8'hC8, 8'h1A, 8'hC8, 8'h58);
      wr(8'h18, 8'h00, 2'b00);
    end
  endtask
  task t_fault;
    begin
      front_u.conv(16'h0331, 16'h0331, 3'b001);
      res(8'h80, 8'h00, 8'h00, 8'h00, 8'h19);
      rd(8'h14, 8'h00, 2'b00);
      pins(2'b11);
      front_u.conv(16'h0331, 16'h0331, 3'b010);
      res(8'h7F, 8'h00, 8'hFF, 8'h00, 8'h19);
      rd(8'h14, 8'h16, 2'b00);
      pins(2'b00);
      front_u.conv(16'h0331, 16'h0331, 3'b100);
      rd(8'h04, 8'h7F, 2'b00);
      rd(8'h14, 8'h16, 2'b00);
      wr(8'h18, 8'h03, 2'b00);
      pins(2'b11);
      wr(8'h1C, 8'h7F, 2'b00);
      wr(8'h24, 8'h7F, 2'b00);
      wr(8'h18, 8'h00, 2'b00);
      // Forced reading equals both setpoints, so only the flag may set
      front_u.conv(16'h0331, 16'h0331, 3'b010);
      rd(8'h14, 8'h04, 2'b00);
      pins(2'b11);
    end
  endtask
  task t_usf;
    begin
      wr(8'h1C, 8'h96, 2'b00);
      rd(8'h20, 8'h96, 2'b00);
      wr(8'h24, 8'hFF, 2'b00);
      wr(8'h18, 8'h04, 2'b00);
      front_u.conv(16'h0C80, 16'h0C80, 3'b000);
      rd(8'h14, 8'h00, 2'b00);
      pins(2'b11);
      wr(8'h18, 8'h00, 2'b00);
      front_u.conv(16'h0C80, 16'h0C80, 3'b000);
      rd(8'h14, 8'h12, 2'b00);
      pins(2'b00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_format;
    t_filter;
    t_fault;
    t_usf;
    end_sim;
  end
endmodule
